// file: design/atb_consts.vh
`ifndef ATB_CONSTS_VH
`define ATB_CONSTS_VH
// Port addresses
`define ATB_PORT_TIMING 16'h1872
`define ATB_PORT_BUSY_CLR 16'h00f0
`define ATB_PORT_COP_RST 16'h00f1
// Field positions in the timing register
`define ATB_SRC_HI 11
`define ATB_SRC_LO 10
`define ATB_RQD_HI 9
`define ATB_RQD_LO 8
`define ATB_ACK_HI 7
`define ATB_ACK_LO 6
`define ATB_IO16_BIT 5
`define ATB_MEM16_BIT 4
`define ATB_IO8_HI 3
`define ATB_IO8_LO 2
`define ATB_MEM8_HI 1
`define ATB_MEM8_LO 0
`define ATB_FIELD_MASK 16'h0fff
// Reset value: source 00, request delay 00, ack delay 11, 16-bit 0, 8-bit 10
`define ATB_TIMING_RESET 16'h00ca
// Coprocessor reset hold in processor clocks
`define ATB_COP_RST_CLOCKS 8'h80
`endif

// file: design/atb_timing.v
`timescale 1ns/1ps
`include "atb_consts.vh"
// How it works
// R1: Two-bit field picks bus logic clock source
// R2: Bus clock is bus logic clock halved
// R3: Asynchronous modes apply sync delays; synchronous skip
// R4: Request sync delay one, half, none
// R5: Completion timed against command strobe trailing edge
// R6: 16-bit I/O one or two waits
// R7: 16-bit memory one or two waits
// R8: 8-bit I/O two to five waits
// R9: 8-bit memory two to five waits
// R10: Write to F0 clears coprocessor busy
// R11: Write to F1 resets coprocessor, waits 128
// R12: Software picks source and delays per system
// R13: Software rechecks source after clock change
// R14: Timing fields low twelve bits, read/write
// R15: Asynchronous inputs pass two-flop synchronisers
// R16: New delays and waits apply from next cycle; new clock source at once
module atb_timing (
	input wire CLK,
	input wire SYS_RST,
	input wire BASE_CLK,
	input wire [15:0] IO_ADDR,
	input wire IO_WR,
	input wire IO_RD,
	input wire [15:0] IO_WDATA,
	output reg [15:0] IO_RDATA,
	input wire CYC_REQ,
	input wire [1:0] CYC_KIND,
	input wire COP_BUSY_SET,
	output reg COP_BUSY,
	output reg COP_RESET,
	output reg CPU_WAIT,
	output reg BUS_CLK,
	output reg CMD_STROBE,
	output reg CYC_DONE
);
	// Cycle kinds
	localparam [1:0] K_MEM8 = 2'h0;
	localparam [1:0] K_IO8 = 2'h1;
	localparam [1:0] K_MEM16 = 2'h2;
	localparam [1:0] K_IO16 = 2'h3;
	localparam [4:0] S_IDLE = 5'h01;
	localparam [4:0] S_SYNC = 5'h02;
	localparam [4:0] S_CMD = 5'h04;
	localparam [4:0] S_HOLD = 5'h08;
	localparam [4:0] S_ACK = 5'h10;
	localparam [7:0] COP_CNT = `ATB_COP_RST_CLOCKS;
	reg [15:0] timing_q;
	reg base_s1_q, base_s2_q, base_s3_q;
	reg half_q;
	reg ph_q;
	reg [4:0] state_q;
	reg [15:0] lat_q;
	reg [1:0] kind_q;
	reg [3:0] cnt_q;
	reg [7:0] cop_q;
	reg [1:0] req_s_q;
	reg pend_q;
	wire base_rise = base_s2_q & ~base_s3_q;
	wire async_src = ~timing_q[`ATB_SRC_HI];
	wire raw_tick = async_src ? base_rise : 1'b1;
	wire div2 = ~timing_q[`ATB_SRC_LO];
	wire logic_tick = raw_tick & (~div2 | half_q); // R1
	wire bus_tick = logic_tick & ph_q; // R2
	wire lat_async = ~lat_q[`ATB_SRC_HI];
	wire req_in = async_src ? req_s_q[1] : CYC_REQ; // R15
	reg [3:0] waits;
	always @*
	begin
		case (kind_q)
			K_IO16: waits = lat_q[`ATB_IO16_BIT] ? 4'h4 : 4'h2; // R6
			K_MEM16: waits = lat_q[`ATB_MEM16_BIT] ? 4'h4 : 4'h2; // R7
			K_IO8: waits = {1'b0, lat_q[`ATB_IO8_HI:`ATB_IO8_LO] + 3'h2} << 1; // R8
			default: waits = {1'b0, lat_q[`ATB_MEM8_HI:`ATB_MEM8_LO] + 3'h2} << 1; // R9
		endcase
	end
	// Counts are in bus logic clocks: one bus clock is two
	reg [3:0] rq_cnt;
	reg [3:0] ack_cnt;
	always @*
	begin
		case (lat_q[`ATB_RQD_HI:`ATB_RQD_LO])
			2'h0: rq_cnt = 4'h2; // R4
			2'h1: rq_cnt = 4'h1; // R4
			default: rq_cnt = 4'h0; // R4
		endcase
		case (lat_q[`ATB_ACK_HI:`ATB_ACK_LO])
			2'h3: ack_cnt = 4'h1; // R5
			default: ack_cnt = 4'h0; // R5
		endcase
	end
	always @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			timing_q <= `ATB_TIMING_RESET;
			base_s1_q <= 1'b0;
			base_s2_q <= 1'b0;
			base_s3_q <= 1'b0;
			req_s_q <= 2'h0;
			half_q <= 1'b0;
			ph_q <= 1'b0;
			BUS_CLK <= 1'b0;
			state_q <= S_IDLE;
			lat_q <= `ATB_TIMING_RESET;
			kind_q <= K_MEM8;
			cnt_q <= 4'h0;
			cop_q <= 8'h00;
			pend_q <= 1'b0;
			COP_BUSY <= 1'b0;
			COP_RESET <= 1'b0;
			CPU_WAIT <= 1'b0;
			CMD_STROBE <= 1'b0;
			CYC_DONE <= 1'b0;
			IO_RDATA <= 16'h0000;
		end
		else
		begin
			base_s1_q <= BASE_CLK; // R15
			base_s2_q <= base_s1_q;
			base_s3_q <= base_s2_q;
			req_s_q <= {req_s_q[0], CYC_REQ}; // R15
			if (raw_tick)
				half_q <= ~half_q;
			if (logic_tick)
			begin
				ph_q <= ~ph_q;
				BUS_CLK <= ~ph_q; // R2
			end
			if (IO_WR && IO_ADDR == `ATB_PORT_TIMING)
				timing_q <= IO_WDATA & `ATB_FIELD_MASK; // R14
			IO_RDATA <= (IO_RD && IO_ADDR == `ATB_PORT_TIMING) ? timing_q : 16'h0000; // R14
			if (COP_BUSY_SET)
				COP_BUSY <= 1'b1;
			else if (IO_WR && IO_ADDR == `ATB_PORT_BUSY_CLR)
				COP_BUSY <= 1'b0; // R10
			if (IO_WR && IO_ADDR == `ATB_PORT_COP_RST && cop_q == 8'h00)
			begin
				cop_q <= COP_CNT; // R11
				COP_RESET <= 1'b1;
				CPU_WAIT <= 1'b1;
			end
			else if (cop_q != 8'h00)
			begin
				cop_q <= cop_q - 8'h01;
				if (cop_q == 8'h01)
				begin
					COP_RESET <= 1'b0;
					CPU_WAIT <= 1'b0; // R11
				end
			end
			CYC_DONE <= 1'b0;
			if (req_in && !CYC_DONE && state_q == S_IDLE)
				pend_q <= 1'b1;
			if (logic_tick)
			begin
				case (state_q)
					S_IDLE:
					begin
						if (pend_q)
						begin
							lat_q <= timing_q; // R16
							kind_q <= CYC_KIND;
							pend_q <= 1'b0;
							state_q <= S_SYNC;
							cnt_q <= 4'h0;
						end
					end
					S_SYNC:
					begin
						if (!lat_async || cnt_q >= rq_cnt) // R3
						begin
							state_q <= S_CMD;
							CMD_STROBE <= 1'b1;
							cnt_q <= 4'h0;
						end
						else
							cnt_q <= cnt_q + 4'h1;
					end
					S_CMD:
					begin
						if (cnt_q + 4'h1 == waits + 4'h2 - (lat_q[`ATB_ACK_HI:`ATB_ACK_LO] == 2'h2 ? 4'h2 :
							lat_q[`ATB_ACK_HI:`ATB_ACK_LO] == 2'h1 ? 4'h1 : 4'h0))
						begin
							// Early completion ahead of the strobe edge
							if (lat_q[`ATB_ACK_HI] ^ lat_q[`ATB_ACK_LO])
								CYC_DONE <= 1'b1; // R5
						end
						if (cnt_q + 4'h1 >= waits + 4'h2)
						begin
							CMD_STROBE <= 1'b0;
							cnt_q <= 4'h0;
							state_q <= S_HOLD;
						end
						else
							cnt_q <= cnt_q + 4'h1;
					end
					S_HOLD:
					begin
						if (cnt_q >= ack_cnt)
						begin
							if (!(lat_q[`ATB_ACK_HI] ^ lat_q[`ATB_ACK_LO]))
								CYC_DONE <= 1'b1; // R5
							state_q <= S_ACK;
						end
						else
							cnt_q <= cnt_q + 4'h1;
					end
					S_ACK:
						state_q <= S_IDLE;
					default:
						state_q <= S_IDLE;
				endcase
			end
		end
	end
endmodule // atb_timing

// file: verification/atb_far_end.sv
`timescale 1ns/1ps
module atb_far_end (
	output logic BASE_CLK
);
	initial BASE_CLK = 0;
	always #31.25 BASE_CLK = ~BASE_CLK;
endmodule // atb_far_end

// file: verification/atb_timing_chk.sv
`timescale 1ns/1ps
module atb_timing_chk (
	input wire CLK,
	input wire SYS_RST,
	input wire [15:0] IO_ADDR,
	input wire IO_WR,
	input wire IO_RD,
	input wire [15:0] IO_RDATA,
	input wire CYC_REQ,
	input wire COP_BUSY_SET,
	input wire COP_BUSY,
	input wire COP_RESET,
	input wire CPU_WAIT,
	input wire CMD_STROBE,
	input wire CYC_DONE
);
	int n = 0;
	always @(posedge CLK)
		n <= COP_RESET ? n + 1 : 0;
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	sequence s_f1_wr;
		IO_WR && IO_ADDR == 16'h00f1 && !COP_RESET;
	endsequence
	a_rd_top_zero: assert property (IO_RD && IO_ADDR == 16'h1872 |=> !IO_RDATA[15:12]) else $error("rd top");
	a_rd_other: assert property (IO_RD && IO_ADDR != 16'h1872 |=> !IO_RDATA) else $error("rd other");
	a_busy_clear: assert property (IO_WR && IO_ADDR == 16'h00f0 && !COP_BUSY_SET |=> !COP_BUSY) else $error("busy");
	a_cop_start: assert property (s_f1_wr |=> COP_RESET && CPU_WAIT) else $error("cop start");
	a_cop_hold: assert property ($fell(COP_RESET) |-> n == 128) else $error("cop hold");
	a_wait_pair: assert property (CPU_WAIT == COP_RESET) else $error("wait");
	a_done_pulse: assert property (CYC_DONE |=> !CYC_DONE) else $error("done");
	a_strobe_req: assert property ($rose(CMD_STROBE) |-> CYC_REQ) else $error("strobe");
endmodule // atb_timing_chk
bind atb_timing atb_timing_chk i_atb_timing_chk (.*);

// file: verification/atb_timing_tb_top.sv
`timescale 1ns/1ps
module atb_timing_tb_top;
	logic clk = 0, rst = 1, wr = 0, rd = 0, req = 0, bset = 0;
	logic [15:0] adr = 0, wd = 0;
	logic [1:0] knd = 0;
	wire bclk, busy, crst, stb, done, bck, wt;
	wire [15:0] rdat;
	int mismatches = 0, check_count = 0, n, len, a;
	always #2.5 clk = ~clk;
	atb_far_end i_atb_far_end (.BASE_CLK(bclk));
	atb_timing i_atb_timing (.CLK(clk), .SYS_RST(rst), .BASE_CLK(bclk), .IO_ADDR(adr), .IO_WR(wr), .IO_RD(rd),
		.IO_WDATA(wd), .IO_RDATA(rdat), .CYC_REQ(req), .CYC_KIND(knd), .COP_BUSY_SET(bset), .COP_BUSY(busy),
		.COP_RESET(crst), .CPU_WAIT(wt), .BUS_CLK(bck), .CMD_STROBE(stb), .CYC_DONE(done));
	task chk(string s, logic [15:0] e, g);
		check_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task io(logic w, logic [15:0] ad, d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		adr <= ad;
		wd <= d;
		@(posedge clk);
		wr <= 0;
		rd <= 0;
		@(negedge clk);
	endtask
	// Strobe clocks of one bus cycle, counted until done
	task cyc(logic [1:0] k);
		@(posedge clk);
		knd <= k;
		req <= 1;
		len = 0;
		for (n = 0; !done && n < 9999; n++)
		begin
			@(negedge clk);
			len += stb;
		end
		@(posedge clk);
		req <= 0;
		repeat (4) @(posedge clk);
	endtask
	task t_regs;
		io(0, 16'h1872, 0);
		chk("timing reset", 16'h00ca, rdat);
		io(1, 16'h1872, 16'hffff);
		io(0, 16'h1872, 0);
		chk("timing rw", 16'h0fff, rdat);
		io(0, 16'h00f1, 0);
		chk("port f1 read", 0, rdat);
	endtask
	task t_cop;
		@(posedge clk);
		bset <= 1;
		@(posedge clk);
		bset <= 0;
		@(negedge clk);
		chk("busy set", 1, busy);
		io(1, 16'h00f0, 16'h1234);
		chk("busy clear", 0, busy);
		io(1, 16'h00f1, 16'h5678);
		chk("cpu wait", 1, wt);
		for (n = 0; crst && n < 300; n++)
			@(negedge clk);
		chk("reset hold", 128, n);
	endtask
	// Mode 11: one bus clock is two clocks, except the last (async strobe) case in mode 01
	task t_waits;
		logic [15:0] f[4] = '{16'h3, 16'hc, 16'h10, 16'h20};
		for (int k = 0; k < 4; k++)
		begin
			io(1, 16'h1872, 16'h0c00);
			cyc(2'(k));
			a = len;
			io(1, 16'h1872, 16'h0c00 | f[k]);
			cyc(2'(k));
			chk("strobe growth", k < 2 ? 6 : 2, len - a);
		end
		io(1, 16'h1872, 16'h0e80);
		cyc(2'h0);
		chk("early done strobe", 5, len);
		io(1, 16'h1872, 16'h04c0);
		cyc(2'h0);
		chk("async strobe", 75, len);
	endtask
	// Bus clock period in clocks for one source setting
	task t_clk(logic [1:0] s, int e);
		io(1, 16'h1872, {4'h0, s, 10'h0ca});
		repeat (2) @(posedge bck);
		a = $time;
		@(posedge bck);
		chk("bus clock period", e, ($time - a) / 5);
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 0;
		t_regs();
		t_cop();
		t_waits();
		t_clk(2'h0, 50);
		t_clk(2'h1, 25);
		t_clk(2'h2, 4);
		t_clk(2'h3, 2);
		give_verdict();
	end
	initial
	begin
		#400000;
		mismatches++;
		give_verdict();
	end
endmodule // atb_timing_tb_top
